//--- mcu_seq_map.svh
// Constants for the instruction timing decoder and sequencer
`ifndef MCU_SEQ_MAP_SVH
`define MCU_SEQ_MAP_SVH

// Stack pointer value after reset
`define SP_RESET_VALUE 8'h07
// Spare opcode that behaves as the idle operation
`define OPC_IDLE_ALIAS 8'ha5
// Mask of the accumulator bits swapped by the low nibble exchange
`define NIBBLE_LOW_MASK 8'h0f
// Cycles added on top of the byte count, per instruction group
`define EXTRA_NONE 4'h0
`define EXTRA_IND 4'h1
`define EXTRA_JUMP 4'h1
`define EXTRA_XFER 4'h2
`define EXTRA_MUL 4'h3
`define EXTRA_RET 4'h4
`define EXTRA_DIV 4'h7
// Cycles added when a conditional branch is taken
`define EXTRA_TAKEN 4'h1
// Stack pointer steps for single bytes and return addresses
`define SP_STEP_BYTE 8'h01
`define SP_STEP_ADDR 8'h02
// Page field width of absolute call and jump targets
`define PAGE_LOW_BITS 11
// Direct operand address bit that marks special function register space
`define SFR_BASE_BIT 7

`endif

//--- mcu_seq_pkg.sv
// Types shared by the instruction timing decoder and sequencer
package mcu_seq_pkg;

  // Instruction groups that the sequencer handles differently
  typedef enum logic [3:0] {
    K_PLAIN = 4'h0,
    K_COND = 4'h1,
    K_JBC = 4'h2,
    K_PAGE = 4'h3,
    K_LONG = 4'h4,
    K_SHORT_RELATIVE_JUMP = 4'h5,
    K_JMPI = 4'h6,
    K_RET = 4'h7,
    K_EXT_SPACE_MOVE = 4'h8,
    K_CODE_BYTE_LOAD = 4'h9,
    K_PUSH = 4'ha,
    K_POP = 4'hb,
    K_LOW_NIBBLE_EXCHANGE = 4'hc
  } op_kind_t;

  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } seq_state_t;

endpackage : mcu_seq_pkg

//--- opcode_timing_decode.sv
// Opcode table: byte length, base cycle count and instruction group
`timescale 1ns/1ps
`include "mcu_seq_map.svh"
module opcode_timing_decode
  import mcu_seq_pkg::*;
(
  // Opcode under decode
  input wire logic [7:0] opcode_in,
  // Decoded length in bytes, 1 to 3
  output logic [1:0] len_out,
  // Cycles when not branching
  output logic [3:0] cycles_out,
  // Instruction group
  output mcu_seq_pkg::op_kind_t kind_out,
  // First operand byte is a direct address
  output logic direct_out
);

  logic [3:0] hi; // Opcode row
  logic [3:0] lo; // Opcode column
  logic [3:0] extra; // Cycles beyond the byte count
  assign hi = opcode_in[7:4];
  assign lo = opcode_in[3:0];

  // Table walk: time equals bytes unless a group adds cycles
  always_comb
  begin
    len_out = 2'd1;
    extra = `EXTRA_NONE;
    kind_out = K_PLAIN;
    direct_out = 1'b0;
    if (lo[3])
    begin
      // Bank register column
      case (hi)
        4'h7, 4'h8, 4'ha: len_out = 2'd2;
        4'hb: begin len_out = 2'd3; kind_out = K_COND; end
        4'hd: begin len_out = 2'd2; kind_out = K_COND; end
        default: len_out = 2'd1;
      endcase
    end
    else
    begin
      case (lo)
        4'h0:
        case (hi)
          4'h0: len_out = 2'd1;
          4'h1: begin len_out = 2'd3; kind_out = K_JBC; end
          4'h2, 4'h3: begin len_out = 2'd3; kind_out = K_COND; end
          4'h4, 4'h5, 4'h6, 4'h7: begin len_out = 2'd2; kind_out = K_COND; end
          4'h8: begin len_out = 2'd2; extra = `EXTRA_JUMP; kind_out = K_SHORT_RELATIVE_JUMP; end
          4'h9: len_out = 2'd3;
          4'hc: begin len_out = 2'd2; kind_out = K_PUSH; direct_out = 1'b1; end
          4'hd: begin len_out = 2'd2; kind_out = K_POP; direct_out = 1'b1; end
          4'he, 4'hf: begin extra = `EXTRA_XFER; kind_out = K_EXT_SPACE_MOVE; end
          default: len_out = 2'd2;
        endcase
        4'h1: begin len_out = 2'd2; extra = `EXTRA_JUMP; kind_out = K_PAGE; end
        4'h2:
        case (hi)
          4'h0, 4'h1: begin len_out = 2'd3; extra = `EXTRA_JUMP; kind_out = K_LONG; end
          4'h2, 4'h3: begin extra = `EXTRA_RET; kind_out = K_RET; end
          4'he, 4'hf: begin extra = `EXTRA_XFER; kind_out = K_EXT_SPACE_MOVE; end
          default: begin len_out = 2'd2; direct_out = 1'b1; end
        endcase
        4'h3:
        case (hi)
          4'h4, 4'h5, 4'h6: begin len_out = 2'd3; direct_out = 1'b1; end
          4'h7: begin extra = `EXTRA_XFER; kind_out = K_JMPI; end
          4'h8, 4'h9: begin extra = `EXTRA_XFER; kind_out = K_CODE_BYTE_LOAD; end
          4'he, 4'hf: begin extra = `EXTRA_XFER; kind_out = K_EXT_SPACE_MOVE; end
          default: len_out = 2'd1;
        endcase
        4'h4:
        case (hi)
          4'h8: extra = `EXTRA_DIV;
          4'ha: extra = `EXTRA_MUL;
          4'hb: begin len_out = 2'd3; kind_out = K_COND; end
          4'h0, 4'h1, 4'hc, 4'hd, 4'he, 4'hf: len_out = 2'd1;
          default: len_out = 2'd2;
        endcase
        4'h5:
        case (hi)
          4'h7, 4'h8: begin len_out = 2'd3; direct_out = 1'b1; end
          4'ha: len_out = 2'd1;
          4'hb, 4'hd: begin len_out = 2'd3; kind_out = K_COND; direct_out = 1'b1; end
          default: begin len_out = 2'd2; direct_out = 1'b1; end
        endcase
        default:
        // Indirect index register columns
        case (hi)
          4'h7, 4'h8, 4'ha: len_out = 2'd2;
          4'hb: begin len_out = 2'd3; extra = `EXTRA_IND; kind_out = K_COND; end
          4'hd: begin extra = `EXTRA_IND; kind_out = K_LOW_NIBBLE_EXCHANGE; end
          default: extra = `EXTRA_IND;
        endcase
      endcase
    end
  end

  // Base count; the table never exceeds eight
  assign cycles_out = {2'b00, len_out} + extra;

endmodule : opcode_timing_decode

//--- mcu_instruction_timing_decoder.sv
// Instruction sequencer: cycle timing, targets, stack and operand routing
`timescale 1ns/1ps
`include "mcu_seq_map.svh"
module mcu_instruction_timing_decoder
  import mcu_seq_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Instruction issue from fetch
  input wire logic issue_valid_in,
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] operand1_in,
  input wire logic [7:0] operand2_in,
  input wire logic [15:0] next_pc_in,
  input wire logic branch_taken_in,
  // Datapath state read by addressing
  input wire logic [7:0] acc_in,
  input wire logic [15:0] data_pointer_16_in,
  input wire logic [7:0] index_value_in,
  input wire logic [1:0] bank_select_in,
  input wire logic program_store_control_in,
  // Sequencing
  output logic ready_out,
  output logic done_out,
  output logic [1:0] length_out,
  output logic [3:0] cycles_out,
  // Branch targets
  output logic target_valid_out,
  output logic [15:0] target_pc_out,
  // Operand routing
  output logic [7:0] bank_register_addr_out,
  output logic [7:0] indirect_index_register_out,
  output logic direct_is_sfr_out,
  output logic [7:0] nibble_mask_out,
  output logic bit_clear_out,
  // Code and external space access
  output logic [15:0] code_addr_out,
  output logic code_read_out,
  output logic [15:0] ext_addr_out,
  output logic ext_write_out,
  output logic ext_flash_sel_out,
  output logic ext_ram_sel_out,
  // Stack
  output logic [7:0] stack_pointer_out,
  output logic [7:0] stack_addr_out
);

  import mcu_seq_pkg::*;

  // Plain 16-bit add used for relative targets and indexed addresses
  function automatic logic [15:0] add16(input logic [15:0] base, input logic [15:0] offs);
    add16 = base + offs;
  endfunction : add16

  // Address of one register inside the selected eight-byte register bank
  function automatic logic [7:0] bank_addr(input logic [1:0] bank, input logic [2:0] reg_num);
    bank_addr = {3'b000, bank, reg_num};
  endfunction : bank_addr

  // Decoder results for the offered opcode
  logic [1:0] dec_len; // Bytes
  logic [3:0] dec_cycles; // Cycles when not branching
  op_kind_t dec_kind; // Group
  logic dec_direct; // Operand one is a direct address
  logic issue; // Instruction accepted this cycle
  logic is_cond; // Conditional branch of any form
  logic taken; // Condition holds
  logic [7:0] rel_byte; // Displacement byte
  logic [15:0] rel_target; // Next address plus displacement
  logic [15:0] page_target; // Page-relative target
  logic [15:0] long_target; // Full 16-bit target
  logic [15:0] indexed_addr; // Accumulator plus data pointer

  // Sequencer state
  seq_state_t state_q;
  logic [3:0] remain_q; // Cycles left after the current one
  logic done_q;
  logic [1:0] length_q;
  logic [3:0] cycles_q;
  op_kind_t kind_q;
  logic taken_q;
  // Target and routing registers
  logic target_valid_q;
  logic [15:0] target_q;
  logic [7:0] bank_reg_q;
  logic [7:0] index_reg_q;
  logic sfr_q;
  logic bit_clear_q;
  logic [15:0] code_addr_q;
  logic code_read_q;
  logic [15:0] ext_addr_q;
  logic ext_write_q;
  logic ext_flash_q;
  logic ext_ram_q;
  // Stack registers
  logic [7:0] sp_q;
  logic [7:0] stack_addr_q;
  // Cycle counter read only by the checks
  logic [3:0] elapsed_q;

  // Table lookup; opcodes keep their classic meaning, and the spare 0xa5 decodes as the idle operation
  opcode_timing_decode u_decode (
    .opcode_in(opcode_in),
    .len_out(dec_len),
    .cycles_out(dec_cycles),
    .kind_out(dec_kind),
    .direct_out(dec_direct)
  );

  // Handshake: one instruction in flight at a time
  assign ready_out = (state_q == ST_IDLE);
  assign issue = issue_valid_in && ready_out;
  assign is_cond = (dec_kind == K_COND) || (dec_kind == K_JBC);
  assign taken = is_cond && branch_taken_in;

  // Displacement is the last operand byte of the instruction
  assign rel_byte = (dec_len == 2'd3) ? operand2_in : operand1_in;
  assign rel_target = add16(next_pc_in, {{8{rel_byte[7]}}, rel_byte});
  assign page_target = {next_pc_in[15:`PAGE_LOW_BITS], opcode_in[7:5], operand1_in};
  assign long_target = {operand1_in, operand2_in};
  assign indexed_addr = add16(data_pointer_16_in, {8'h00, acc_in});

  // Cycle sequencer; the count is bare clock cycles
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      state_q <= ST_IDLE;
      remain_q <= 4'h0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        if (issue)
        begin
          // Taken branch holds one cycle longer
          if (dec_cycles == 4'h1 && !taken)
            done_q <= 1'b1;
          else
          begin
            state_q <= ST_EXEC;
            remain_q <= dec_cycles + (taken ? `EXTRA_TAKEN : 4'h0) - 4'h2;
          end
        end
        ST_EXEC:
        if (remain_q == 4'h0)
        begin
          state_q <= ST_IDLE;
          done_q <= 1'b1;
        end
        else
          remain_q <= remain_q - 4'h1;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Instruction summary held until the next issue
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      length_q <= 2'd0;
      cycles_q <= 4'h0;
      kind_q <= K_PLAIN;
      taken_q <= 1'b0;
    end
    else if (issue)
    begin
      length_q <= dec_len;
      cycles_q <= dec_cycles + (taken ? `EXTRA_TAKEN : 4'h0);
      kind_q <= dec_kind;
      taken_q <= taken;
    end
  end

  // Target selection per branch group
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      target_valid_q <= 1'b0;
      target_q <= 16'h0000;
      bit_clear_q <= 1'b0;
    end
    else if (issue)
    begin
      target_valid_q <= 1'b1;
      bit_clear_q <= (dec_kind == K_JBC) && taken;
      case (dec_kind)
        K_COND, K_JBC: begin target_q <= rel_target; target_valid_q <= taken; end
        K_SHORT_RELATIVE_JUMP: target_q <= rel_target;
        K_PAGE: target_q <= page_target;
        K_LONG: target_q <= long_target;
        K_JMPI: target_q <= indexed_addr;
        // Return address comes from the stack, not from here
        default: begin target_q <= next_pc_in; target_valid_q <= 1'b0; end
      endcase
    end
  end

  // Operand routing: bank registers, index registers, direct space
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      bank_reg_q <= 8'h00;
      index_reg_q <= 8'h00;
      sfr_q <= 1'b0;
    end
    else if (issue)
    begin
      bank_reg_q <= bank_addr(bank_select_in, opcode_in[2:0]);
      index_reg_q <= bank_addr(bank_select_in, {2'b00, opcode_in[0]});
      // Upper half of direct space is special registers, not RAM
      sfr_q <= dec_direct && operand1_in[`SFR_BASE_BIT];
    end
  end

  // Code byte load and external space move addressing
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      code_addr_q <= 16'h0000;
      code_read_q <= 1'b0;
      ext_addr_q <= 16'h0000;
      ext_write_q <= 1'b0;
      ext_flash_q <= 1'b0;
      ext_ram_q <= 1'b0;
    end
    else if (issue)
    begin
      code_read_q <= (dec_kind == K_CODE_BYTE_LOAD);
      // Row 9 indexes from the data pointer, row 8 from the next address
      code_addr_q <= opcode_in[4] ? indexed_addr : add16(next_pc_in, {8'h00, acc_in});
      // Column 0 uses the data pointer, columns 2-3 an index register
      ext_addr_q <= opcode_in[1] ? {8'h00, index_value_in} : data_pointer_16_in;
      ext_write_q <= (dec_kind == K_EXT_SPACE_MOVE) && opcode_in[4];
      ext_flash_q <= (dec_kind == K_EXT_SPACE_MOVE) && program_store_control_in;
      ext_ram_q <= (dec_kind == K_EXT_SPACE_MOVE) && !program_store_control_in;
    end
    else
    begin
      // Strobes last one cycle so memories see a single access
      code_read_q <= 1'b0;
      ext_flash_q <= 1'b0;
      ext_ram_q <= 1'b0;
      ext_write_q <= 1'b0;
    end
  end

  // Stack pointer: push pre-increments, pop post-decrements
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      sp_q <= `SP_RESET_VALUE;
      stack_addr_q <= `SP_RESET_VALUE;
    end
    else if (issue)
    begin
      case (dec_kind)
        K_PUSH:
        begin
          sp_q <= sp_q + `SP_STEP_BYTE;
          stack_addr_q <= sp_q + `SP_STEP_BYTE;
        end
        K_POP:
        begin
          sp_q <= sp_q - `SP_STEP_BYTE;
          stack_addr_q <= sp_q;
        end
        K_PAGE, K_LONG:
        // Only calls push a return address; opcode bit 4 marks a call
        if (opcode_in[4])
        begin
          sp_q <= sp_q + `SP_STEP_ADDR;
          stack_addr_q <= sp_q + `SP_STEP_BYTE;
        end
        K_RET:
        begin
          sp_q <= sp_q - `SP_STEP_ADDR;
          stack_addr_q <= sp_q;
        end
        default: stack_addr_q <= sp_q;
      endcase
    end
  end

  // Cycles since issue, for timing checks only
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
      elapsed_q <= 4'h0;
    else if (issue)
      elapsed_q <= 4'h1;
    else if (state_q == ST_EXEC)
      elapsed_q <= elapsed_q + 4'h1;
  end

  // Output drive, all from flops
  assign done_out = done_q;
  assign length_out = length_q;
  assign cycles_out = cycles_q;
  assign target_valid_out = target_valid_q;
  assign target_pc_out = target_q;
  assign bank_register_addr_out = bank_reg_q;
  assign indirect_index_register_out = index_reg_q;
  assign direct_is_sfr_out = sfr_q;
  // Low nibble exchange touches bits 3..0 only
  assign nibble_mask_out = (kind_q == K_LOW_NIBBLE_EXCHANGE) ? `NIBBLE_LOW_MASK : 8'hff;
  assign bit_clear_out = bit_clear_q;
  assign code_addr_out = code_addr_q;
  assign code_read_out = code_read_q;
  assign ext_addr_out = ext_addr_q;
  assign ext_write_out = ext_write_q;
  assign ext_flash_sel_out = ext_flash_q;
  assign ext_ram_sel_out = ext_ram_q;
  assign stack_pointer_out = sp_q;
  assign stack_addr_out = stack_addr_q;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  chk_done_count: assert property (done_out |-> elapsed_q == cycles_q)
    else $error("done not at decoded cycle count");
  chk_untaken_short: assert property (
    (issue && is_cond) |=> cycles_q == $past(dec_len) + {3'b000, $past(taken)}
      + ((kind_q == K_COND && $past(opcode_in[3:1]) == 3'b011) ? 4'h1 : 4'h0))
    else $error("conditional branch timing wrong");
  chk_ind_alu: assert property (
    (issue && opcode_in == 8'h26) |-> ##2 done_out)
    else $error("indirect add not two cycles");
  chk_xfer_three: assert property (
    (issue && dec_kind == K_EXT_SPACE_MOVE) |=> !done_out[*2] ##1 done_out)
    else $error("external move not three cycles");
  chk_compare_jump_unequal_ind: assert property (
    (issue && opcode_in[7:1] == 7'h5b) |=> cycles_q == 4'h4 + {3'b000, taken_q})
    else $error("indirect compare jump timing wrong");
  chk_rel_target: assert property (
    (issue && dec_kind == K_SHORT_RELATIVE_JUMP) |=> target_pc_out ==
      $past(next_pc_in) + {{8{$past(operand1_in[7])}}, $past(operand1_in)})
    else $error("relative target wrong");
  chk_page_keep: assert property (
    (issue && dec_kind == K_PAGE) |=> target_pc_out[15:11] == $past(next_pc_in[15:11]))
    else $error("page target left its page");
  chk_direct_sfr: assert property (
    (issue && opcode_in == 8'he5) |=> direct_is_sfr_out == $past(operand1_in[7]))
    else $error("direct space select wrong");
  chk_flash_route: assert property (
    (issue && dec_kind == K_EXT_SPACE_MOVE && program_store_control_in)
      |=> ext_flash_sel_out && !ext_ram_sel_out)
    else $error("external move missed flash");
  chk_ram_route: assert property (
    (issue && dec_kind == K_EXT_SPACE_MOVE && !program_store_control_in)
      |=> ext_ram_sel_out && !ext_flash_sel_out)
    else $error("external move missed RAM");
  chk_sp_reset: assert property ($rose(resetn_in) |-> stack_pointer_out == 8'h07)
    else $error("stack pointer reset value wrong");
  chk_push_step: assert property (
    (issue && dec_kind == K_PUSH) |=> stack_addr_out == stack_pointer_out
      && stack_pointer_out == $past(stack_pointer_out) + 8'h01)
    else $error("push did not pre-increment");

endmodule : mcu_instruction_timing_decoder

//--- tb_mcu_instruction_timing_decoder.sv
// Self-checking bench for the instruction timing decoder and sequencer
`timescale 1ns/1ps
module tb_mcu_instruction_timing_decoder;
  import mcu_seq_pkg::*;
  // Clock, reset and issue side
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic issue_valid_in = 1'b0;
  logic branch_taken_in = 1'b0;
  logic program_store_control_in = 1'b0;
  logic [7:0] opcode_in = 8'h00, operand1_in = 8'h00, operand2_in = 8'h00;
  logic [7:0] acc_in = 8'h00, index_value_in = 8'h00;
  logic [15:0] next_pc_in = 16'h0000, data_pointer_16_in = 16'h0000;
  logic [1:0] bank_select_in = 2'b00;
  // Design outputs
  logic ready_out, done_out, target_valid_out, direct_is_sfr_out, bit_clear_out;
  logic code_read_out, ext_write_out, ext_flash_sel_out, ext_ram_sel_out;
  logic [1:0] length_out;
  logic [3:0] cycles_out;
  logic [7:0] bank_register_addr_out, indirect_index_register_out, nibble_mask_out;
  logic [7:0] stack_pointer_out, stack_addr_out;
  logic [15:0] target_pc_out, code_addr_out, ext_addr_out;
  // Strobes caught in the cycle after issue, they stand one cycle only
  logic cap_ram, cap_flash, cap_wr, cap_rd;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;

  mcu_instruction_timing_decoder dut (.clock_in, .resetn_in, .issue_valid_in, .opcode_in,
    .operand1_in, .operand2_in, .next_pc_in, .branch_taken_in, .acc_in, .data_pointer_16_in,
    .index_value_in, .bank_select_in, .program_store_control_in, .ready_out, .done_out,
    .length_out, .cycles_out, .target_valid_out, .target_pc_out, .bank_register_addr_out,
    .indirect_index_register_out, .direct_is_sfr_out, .nibble_mask_out, .bit_clear_out,
    .code_addr_out, .code_read_out, .ext_addr_out, .ext_write_out, .ext_flash_sel_out,
    .ext_ram_sel_out, .stack_pointer_out, .stack_addr_out);

  // 200 MHz clock
  always #2.5 clock_in = ~clock_in;

  // Hang guard, whole run needs well under a thousand cycles
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      wrap_up();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // One issue, entered just after an edge with ready high; returns in the done cycle
  task automatic run_op(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
      input logic tk, input logic [1:0] len, input logic [3:0] n_exp);
    int n;
    {opcode_in, operand1_in, operand2_in, branch_taken_in} = {op, b1, b2, tk};
    issue_valid_in = 1'b1;
    @(posedge clock_in);
    #1;
    // Left high after a one-cycle op, the next call issues back to back
    if (done_out !== 1'b1)
      issue_valid_in = 1'b0;
    {cap_ram, cap_flash, cap_wr, cap_rd} =
      {ext_ram_sel_out, ext_flash_sel_out, ext_write_out, code_read_out};
    n = 1;
    while (done_out !== 1'b1 && n < 12)
    begin
      @(posedge clock_in);
      #1;
      n++;
    end
    chk(16'(n), 16'(n_exp), "done cycle");
    chk(16'(length_out), 16'(len), "length");
    chk(16'(cycles_out), 16'(n_exp), "cycles");
  endtask : run_op

  // Fixed lengths and cycle counts
  task automatic t_timing;
    run_op(8'h00, 8'h00, 8'h00, 1'b0, 2'd1, 4'd1);
    run_op(8'ha5, 8'h00, 8'h00, 1'b0, 2'd1, 4'd1);
    run_op(8'h25, 8'h30, 8'h00, 1'b0, 2'd2, 4'd2);
    run_op(8'h74, 8'h30, 8'h00, 1'b0, 2'd2, 4'd2);
    run_op(8'h26, 8'h00, 8'h00, 1'b0, 2'd1, 4'd2);
    run_op(8'h53, 8'h30, 8'h0f, 1'b0, 2'd3, 4'd3);
    run_op(8'h43, 8'h30, 8'h0f, 1'b0, 2'd3, 4'd3);
    run_op(8'h63, 8'h30, 8'h0f, 1'b0, 2'd3, 4'd3);
    run_op(8'h80, 8'h02, 8'h00, 1'b0, 2'd2, 4'd3);
    run_op(8'h32, 8'h00, 8'h00, 1'b0, 2'd1, 4'd5);
    run_op(8'ha4, 8'h00, 8'h00, 1'b0, 2'd1, 4'd4);
    run_op(8'h84, 8'h00, 8'h00, 1'b0, 2'd1, 4'd8);
  endtask : t_timing

  // Conditional forms, fall-through then taken
  task automatic t_branch;
    for (int t = 0; t < 2; t++)
    begin
      run_op(8'h40, 8'h04, 8'h00, t[0], 2'd2, 4'(2 + t));
      run_op(8'h20, 8'h21, 8'h04, t[0], 2'd3, 4'(3 + t));
      run_op(8'hb4, 8'h21, 8'h04, t[0], 2'd3, 4'(3 + t));
      run_op(8'hb6, 8'h21, 8'h04, t[0], 2'd3, 4'(4 + t));
      run_op(8'hd8, 8'h04, 8'h00, t[0], 2'd2, 4'(2 + t));
      run_op(8'hd5, 8'h30, 8'h04, t[0], 2'd3, 4'(3 + t));
      run_op(8'h10, 8'h21, 8'h04, t[0], 2'd3, 4'(3 + t));
      chk(16'(bit_clear_out), 16'(t), "bit clear");
      chk(16'(target_valid_out), 16'(t), "target valid");
    end
  endtask : t_branch

  // Relative, page, long and indexed targets
  task automatic t_targets;
    {next_pc_in, acc_in, data_pointer_16_in} = {16'h1234, 8'h10, 16'h1ff8};
    run_op(8'h80, 8'hfe, 8'h00, 1'b0, 2'd2, 4'd3);
    chk(target_pc_out, 16'h1232, "short jump target");
    run_op(8'h20, 8'h21, 8'h80, 1'b1, 2'd3, 4'd4);
    chk(target_pc_out, 16'h11b4, "bit jump target");
    next_pc_in = 16'h3800;
    run_op(8'he1, 8'h55, 8'h00, 1'b0, 2'd2, 4'd3);
    chk(target_pc_out, 16'h3f55, "page jump target");
    run_op(8'h11, 8'h55, 8'h00, 1'b0, 2'd2, 4'd3);
    chk(target_pc_out, 16'h3855, "page call target");
    run_op(8'h02, 8'hab, 8'hcd, 1'b0, 2'd3, 4'd4);
    chk(target_pc_out, 16'habcd, "long jump target");
    run_op(8'h73, 8'h00, 8'h00, 1'b0, 2'd1, 4'd3);
    chk(target_pc_out, 16'h2008, "indexed target");
  endtask : t_targets

  // External space moves and code byte loads
  task automatic t_ext;
    {data_pointer_16_in, index_value_in, program_store_control_in} = {16'h4321, 8'h9a, 1'b1};
    run_op(8'he0, 8'h00, 8'h00, 1'b0, 2'd1, 4'd3);
    chk(16'({cap_flash, cap_ram, cap_wr}), 16'h0004, "flash read");
    chk(ext_addr_out, 16'h4321, "pointer address");
    program_store_control_in = 1'b0;
    run_op(8'hf0, 8'h00, 8'h00, 1'b0, 2'd1, 4'd3);
    chk(16'({cap_flash, cap_ram, cap_wr}), 16'h0003, "ram write");
    run_op(8'he3, 8'h00, 8'h00, 1'b0, 2'd1, 4'd3);
    chk(ext_addr_out, 16'h009a, "index address");
    {acc_in, next_pc_in} = {8'h05, 16'h1234};
    run_op(8'h93, 8'h00, 8'h00, 1'b0, 2'd1, 4'd3);
    chk(code_addr_out, 16'h4326, "pointer code address");
    chk(16'(cap_rd), 16'h0001, "code read strobe");
    run_op(8'h83, 8'h00, 8'h00, 1'b0, 2'd1, 4'd3);
    chk(code_addr_out, 16'h1239, "counter code address");
  endtask : t_ext

  // Stack from reset, banks, direct space split and nibble mask
  task automatic t_stack_bank;
    run_op(8'hc0, 8'h30, 8'h00, 1'b0, 2'd2, 4'd2);
    chk(16'({stack_pointer_out, stack_addr_out}), 16'h0808, "push");
    run_op(8'h12, 8'h12, 8'h34, 1'b0, 2'd3, 4'd4);
    chk(16'({stack_pointer_out, stack_addr_out}), 16'h0a09, "call push");
    run_op(8'h22, 8'h00, 8'h00, 1'b0, 2'd1, 4'd5);
    run_op(8'hd0, 8'h30, 8'h00, 1'b0, 2'd2, 4'd2);
    chk(16'(stack_pointer_out), 16'h0007, "pop");
    bank_select_in = 2'b10;
    run_op(8'h2b, 8'h00, 8'h00, 1'b0, 2'd1, 4'd1);
    chk(16'(bank_register_addr_out), 16'h0013, "bank register");
    bank_select_in = 2'b11;
    run_op(8'h27, 8'h00, 8'h00, 1'b0, 2'd1, 4'd2);
    chk(16'(indirect_index_register_out), 16'h0019, "index register");
    for (int a = 0; a < 2; a++)
    begin
      run_op(8'he5, 8'(8'h7f + a), 8'h00, 1'b0, 2'd2, 4'd2);
      chk(16'(direct_is_sfr_out), 16'(a), "direct space");
    end
    run_op(8'hd6, 8'h00, 8'h00, 1'b0, 2'd1, 4'd2);
    chk(16'(nibble_mask_out), 16'h000f, "nibble mask");
  endtask : t_stack_bank

  // Offers while busy are ignored
  task automatic t_refuse;
    {opcode_in, issue_valid_in} = {8'h84, 1'b1};
    @(posedge clock_in);
    #1;
    opcode_in = 8'h25;
    repeat (6) @(posedge clock_in);
    #1;
    issue_valid_in = 1'b0;
    @(posedge clock_in);
    #1;
    chk(16'({done_out, cycles_out}), 16'h0018, "busy offer ignored");
  endtask : t_refuse

  // Reset values
  task automatic t_reset;
    resetn_in = 1'b0;
    repeat (4) @(posedge clock_in);
    #1;
    resetn_in = 1'b1;
    @(posedge clock_in);
    #1;
    chk(16'({stack_pointer_out, stack_addr_out}), 16'h0707, "stack reset");
    chk(16'({ready_out, done_out, nibble_mask_out}), 16'h02ff, "idle reset");
  endtask : t_reset

  // Verdict
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial
  begin
    t_reset();
    t_stack_bank();
    t_timing();
    t_branch();
    t_targets();
    t_ext();
    t_refuse();
    t_reset();
    wrap_up();
  end
endmodule : tb_mcu_instruction_timing_decoder
